// ---- hw/tcap_pkg.sv ----
// Constants, register map and decode helpers of the timer capture unit.
// Assumes one APB slave port; printed offsets are register indexes and
// each index maps to byte address four times the index.
// Behaviour
// R1: Capture event copies counter into capture register
// R2: Timer 1 may capture on comparator output
// R3: Capture register may serve as counter top
// R4: Low byte read latches high byte into temp
// R5: One temp byte shared by all 16-bit registers
// R6: Capture register 16 bit, read/write, resets zero
// R7: Mask bits 5,3,2,1,0 read/write, reset zero
// R8: Mask bits 7,6,4 read as zero
// R9: Capture irq needs enable bit and global enable
// R10: Enabled capture irq requested while flag set
// R11: Flag set on capture, cleared by vector or one
// R12: Compare and overflow enables gate irqs alike
// R13: Request is flag AND mask AND global enable
package tcap_pkg;

	localparam int NTMR   = 4;
	localparam int NSRC   = 5;
	localparam int ADDR_W = 12;

	// Register indexes, one per timer; one shared control index
	localparam logic [9:0] IDX_MASK [NTMR] =
		'{10'h06f, 10'h071, 10'h072, 10'h073};
	localparam logic [9:0] IDX_CAPL [NTMR] =
		'{10'h086, 10'h096, 10'h0a6, 10'h126};
	localparam logic [9:0] IDX_CAPH [NTMR] =
		'{10'h087, 10'h097, 10'h0a7, 10'h127};
	localparam logic [9:0] IDX_FLAG [NTMR] =
		'{10'h036, 10'h038, 10'h039, 10'h03a};
	localparam logic [9:0] IDX_CTRL = 10'h010;

	// Mask and flag bit positions
	localparam int BIT_OVF = 0;
	localparam int BIT_CMPA = 1;
	localparam int BIT_CMPB = 2;
	localparam int BIT_CMPC = 3;
	localparam int BIT_CAP = 5;
	localparam logic [7:0] MASK_RW = 8'h2f;

	// Control register fields
	localparam int CTRL_GIE = 0;
	localparam int CTRL_ACSEL = 1;
	localparam int CTRL_TOP_LSB = 4;
	localparam logic [7:0] CTRL_RW = 8'hf3;

	// Reset values and fixed top
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [31:0] RST_DATA = 32'h0000_0000;
	localparam logic [15:0] FIXED_TOP = 16'hffff;

	typedef enum logic [2:0] {
		TCAP_K_NONE,
		TCAP_K_MASK,
		TCAP_K_CAPL,
		TCAP_K_CAPH,
		TCAP_K_FLAG,
		TCAP_K_CTRL
	} tcap_kind_e;

	// Kind of register at an index
	function automatic tcap_kind_e tcap_dec_kind(input logic [9:0] idx);
		tcap_kind_e k;
		k = TCAP_K_NONE;
		if (idx == IDX_CTRL) begin
			k = TCAP_K_CTRL;
		end
		for (int t = 0; t < NTMR; t++) begin
			if (idx == IDX_MASK[t]) k = TCAP_K_MASK;
			if (idx == IDX_CAPL[t]) k = TCAP_K_CAPL;
			if (idx == IDX_CAPH[t]) k = TCAP_K_CAPH;
			if (idx == IDX_FLAG[t]) k = TCAP_K_FLAG;
		end
		return k;
	endfunction

	// Timer number of a per-timer register
	function automatic logic [1:0] tcap_dec_tmr(input logic [9:0] idx);
		logic [1:0] n;
		n = 2'h0;
		for (int t = 0; t < NTMR; t++) begin
			if (idx == IDX_MASK[t] || idx == IDX_CAPL[t] ||
			    idx == IDX_CAPH[t] || idx == IDX_FLAG[t]) begin
				n = 2'(t);
			end
		end
		return n;
	endfunction

	// Flag bit of interrupt source k: ovf, cmp a, b, c, capture
	function automatic int tcap_src_bit(input int k);
		return (k < 4) ? k : BIT_CAP;
	endfunction

endpackage

// ---- hw/tcap_sync.sv ----
// Two-flop synchroniser for asynchronous level inputs.
// Assumes the inputs are slow against the clock; no pulse stretching.
`timescale 1ns/100ps
module tcap_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule // tcap_sync

// ---- hw/tcap_top.sv ----
// Input capture, capture-as-top and interrupt masking for four timers.
// Assumes counter value and compare/overflow strobes come from counter
// logic on pclk; capture pins and comparator output are asynchronous.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
module tcap_top (
	// APB clock and reset
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	// APB slave
	input  wire logic [tcap_pkg::ADDR_W-1:0] paddr,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	// Asynchronous capture sources
	input  wire logic [3:0]                  capture_input_pin,
	input  wire logic                        comparator_out,
	// Counter side, synchronous to pclk
	input  wire logic [63:0]                 counter_value,
	input  wire logic [3:0]                  cmp_a_evt,
	input  wire logic [3:0]                  cmp_b_evt,
	input  wire logic [3:0]                  cmp_c_evt,
	input  wire logic [3:0]                  ovf_evt,
	output logic      [63:0]                 counter_top,
	// Interrupt side
	input  wire logic [19:0]                 vector_ack,
	output logic      [19:0]                 tmr_irq_req,
	output logic                             irq
);

	localparam int NT = tcap_pkg::NTMR;
	localparam int NS = tcap_pkg::NSRC;

	logic [7:0]  mask_q [NT];
	logic [7:0]  flag_q [NT];
	logic [15:0] cap_q  [NT];
	logic [7:0]  temp_q;
	logic [7:0]  ctrl_q;
	logic [4:0]  src_sync;
	logic [4:0]  src_prev_q;
	logic [4:0]  src_rise;
	logic [NT-1:0] match_q;
	logic [NT-1:0] match_now;
	logic [NT-1:0] cap_evt;
	logic [NT-1:0] top_sel;
	logic [NT-1:0] top_hit;

	logic [9:0]             acc_idx;
	logic                   acc_aligned;
	tcap_pkg::tcap_kind_e   acc_kind;
	logic [1:0]             acc_tmr;
	logic                   acc_done;
	logic                   wr_done;
	logic                   rd_done;
	logic                   unmapped;
	logic [7:0]             rdata_d;
	logic                   gie;

	// Capture pins and comparator cross into pclk first
	tcap_sync #(
		.W (5)
	) u_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     ({comparator_out, capture_input_pin}),
		.q     (src_sync)
	);

	// Rising edge of each synchronised source
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_prev_q <= 5'h00;
		end else begin
			src_prev_q <= src_sync;
		end
	end

	assign src_rise = src_sync & ~src_prev_q;
	assign gie = ctrl_q[tcap_pkg::CTRL_GIE];

	// Capture source and top selection per timer
	always_comb begin
		for (int t = 0; t < NT; t++) begin
			top_sel[t] = ctrl_q[tcap_pkg::CTRL_TOP_LSB + t]; // R3
			if (t == 0 && ctrl_q[tcap_pkg::CTRL_ACSEL]) begin
				cap_evt[t] = src_rise[4]; // R2
			end else begin
				cap_evt[t] = src_rise[t];
			end
			match_now[t] = (counter_value[t*16 +: 16] == cap_q[t]);
			// Top reached flags once, on entry to the match
			top_hit[t] = top_sel[t] & match_now[t] & ~match_q[t];
		end
	end

	// Previous top match, for the one-shot top flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_q <= '0;
		end else begin
			match_q <= match_now;
		end
	end

	// APB access decode; effects land on the completing edge
	assign acc_idx     = paddr[11:2];
	assign acc_aligned = (paddr[1:0] == 2'h0);
	assign acc_kind    = tcap_pkg::tcap_dec_kind(acc_idx);
	assign acc_tmr     = tcap_pkg::tcap_dec_tmr(acc_idx);
	assign acc_done    = psel & penable & pready;
	assign wr_done     = acc_done & pwrite & ~unmapped;
	assign rd_done     = acc_done & ~pwrite & ~unmapped;
	assign unmapped    = ~acc_aligned | (acc_kind == tcap_pkg::TCAP_K_NONE);

	// Read data mux; the high byte reads the shared temp byte
	always_comb begin
		rdata_d = tcap_pkg::RST_BYTE;
		unique case (acc_kind)
			tcap_pkg::TCAP_K_MASK: rdata_d = mask_q[acc_tmr]; // R8
			tcap_pkg::TCAP_K_CAPL: rdata_d = cap_q[acc_tmr][7:0];
			tcap_pkg::TCAP_K_CAPH: rdata_d = temp_q; // R4
			tcap_pkg::TCAP_K_FLAG: rdata_d = flag_q[acc_tmr];
			tcap_pkg::TCAP_K_CTRL: rdata_d = ctrl_q;
			tcap_pkg::TCAP_K_NONE: rdata_d = tcap_pkg::RST_BYTE;
		endcase
	end

	// One wait state keeps prdata and pready straight from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= tcap_pkg::RST_DATA;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & unmapped;
			if (psel && penable && !pready && !pwrite && !unmapped) begin
				prdata <= {24'h00_0000, rdata_d};
			end else begin
				prdata <= tcap_pkg::RST_DATA;
			end
		end
	end

	// Shared temp byte: loaded by low reads and high writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			temp_q <= tcap_pkg::RST_BYTE;
		end else if (rd_done && acc_kind == tcap_pkg::TCAP_K_CAPL) begin
			temp_q <= cap_q[acc_tmr][15:8]; // R4 R5
		end else if (wr_done && acc_kind == tcap_pkg::TCAP_K_CAPH) begin
			temp_q <= pwdata[7:0]; // R5
		end
	end

	// Capture registers; pin capture is held off while used as top
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int t = 0; t < NT; t++) begin
				cap_q[t] <= tcap_pkg::RST_WORD; // R6
			end
		end else begin
			for (int t = 0; t < NT; t++) begin
				if (cap_evt[t] && !top_sel[t]) begin
					cap_q[t] <= counter_value[t*16 +: 16]; // R1
				end else if (wr_done && acc_tmr == 2'(t) &&
				             acc_kind == tcap_pkg::TCAP_K_CAPL) begin
					cap_q[t] <= {temp_q, pwdata[7:0]}; // R6
				end
			end
		end
	end

	// Mask registers; reserved bits never store
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int t = 0; t < NT; t++) begin
				mask_q[t] <= tcap_pkg::RST_BYTE; // R7
			end
		end else begin
			for (int t = 0; t < NT; t++) begin
				if (wr_done && acc_tmr == 2'(t) &&
				    acc_kind == tcap_pkg::TCAP_K_MASK) begin
					mask_q[t] <= pwdata[7:0] & tcap_pkg::MASK_RW; // R7 R8
				end
			end
		end
	end

	// Control: global enable, comparator select, top select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= tcap_pkg::RST_BYTE;
		end else if (wr_done && acc_kind == tcap_pkg::TCAP_K_CTRL) begin
			ctrl_q <= pwdata[7:0] & tcap_pkg::CTRL_RW;
		end
	end

	// Flags: set beats clear so no event is lost in the clear cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int t = 0; t < NT; t++) begin
				flag_q[t] <= tcap_pkg::RST_BYTE;
			end
		end else begin
			for (int t = 0; t < NT; t++) begin
				logic [7:0] set_v;
				logic [7:0] clr_v;
				set_v = 8'h00;
				clr_v = 8'h00;
				set_v[tcap_pkg::BIT_CAP]  = cap_evt[t] | top_hit[t]; // R11
				set_v[tcap_pkg::BIT_CMPA] = cmp_a_evt[t];
				set_v[tcap_pkg::BIT_CMPB] = cmp_b_evt[t];
				set_v[tcap_pkg::BIT_CMPC] = cmp_c_evt[t];
				set_v[tcap_pkg::BIT_OVF]  = ovf_evt[t];
				for (int k = 0; k < NS; k++) begin
					clr_v[tcap_pkg::tcap_src_bit(k)] = vector_ack[t*NS + k]; // R11
				end
				if (wr_done && acc_tmr == 2'(t) &&
				    acc_kind == tcap_pkg::TCAP_K_FLAG) begin
					clr_v = clr_v | pwdata[7:0]; // R11
				end
				flag_q[t] <= ((flag_q[t] & ~clr_v) | set_v) & tcap_pkg::MASK_RW;
			end
		end
	end

	// Per-vector requests held while flag, mask and global enable hold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmr_irq_req <= 20'h0_0000;
			irq         <= 1'b0;
		end else begin
			logic any_v;
			any_v = 1'b0;
			for (int t = 0; t < NT; t++) begin
				for (int k = 0; k < NS; k++) begin
					tmr_irq_req[t*NS + k] <=
						flag_q[t][tcap_pkg::tcap_src_bit(k)] &
						mask_q[t][tcap_pkg::tcap_src_bit(k)] & gie; // R9 R10 R12 R13
					any_v = any_v | (flag_q[t][tcap_pkg::tcap_src_bit(k)] &
						mask_q[t][tcap_pkg::tcap_src_bit(k)]);
				end
			end
			irq <= any_v & gie; // R13
		end
	end

	// Counter top: capture value or fixed maximum
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_top <= {4{tcap_pkg::FIXED_TOP}};
		end else begin
			for (int t = 0; t < NT; t++) begin
				counter_top[t*16 +: 16] <= top_sel[t] ? cap_q[t] :
					tcap_pkg::FIXED_TOP; // R3
			end
		end
	end

endmodule // tcap_top

// ---- testbench/tb_tcap_top.sv ----
// Self-checking bench of the timer capture unit over APB.
// Assumes the counter-side model and checker files are compiled first.
`timescale 1ns/100ps
module tb_tcap_top;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        cmp_o = 0, hold = 1, pready, pslverr, irq, se;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic [3:0]  pin = '0;
	logic [15:0] fire = '0, evt;
	logic [19:0] ack = '0, req;
	logic [63:0] cnt, top;
	logic [7:0]  rd;
	logic [19:0] exp_req;
	int          err_count = 0, checked = 0;

	// Free-running bus clock
	always #10 pclk = ~pclk;

	tcap_top tcap_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.capture_input_pin(pin), .comparator_out(cmp_o),
		.counter_value(cnt), .cmp_a_evt(evt[7:4]), .cmp_b_evt(evt[11:8]),
		.cmp_c_evt(evt[15:12]), .ovf_evt(evt[3:0]), .counter_top(top),
		.vector_ack(ack), .tmr_irq_req(req), .irq(irq));
	tcap_cnt_model tcap_cnt_model_i (.pclk(pclk), .presetn(presetn),
		.hold(hold), .fire(fire), .counter_value(cnt), .evt_q(evt));

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// One APB transfer; waits for ready under a bounded count
	task automatic apb(input logic w, input logic [9:0] idx,
		input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h00_0000, wd};
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		// A slave that never answers counts as a mismatch
		if (pready !== 1'b1) begin
			err_count++;
			$display("unexpected at %0t: got %h exp %h", $time, pready, 1'b1);
		end
		rd = prdata[7:0];
		se = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask
	task automatic rdc(input logic [9:0] idx, input logic [7:0] e);
		apb(1'b0, idx, 8'h00);
		chk(64'(rd), 64'(e));
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Watchdog well beyond the sequence length
	initial begin
		tick(20000);
		err_count++;
		tally_and_finish();
	end

	initial begin
		tick(12);
		presetn <= 1;
		chk(top, 64'hffff_ffff_ffff_ffff);
		apb(1'b0, 10'h001, 8'h00);
		chk(64'(se), 64'h1);
		for (int t = 0; t < 4; t++) begin
			rdc(tcap_pkg::IDX_MASK[t], 8'h00);
			rdc(tcap_pkg::IDX_CAPL[t], 8'h00);
			rdc(tcap_pkg::IDX_CAPH[t], 8'h00);
			wr(tcap_pkg::IDX_MASK[t], 8'hff);
			rdc(tcap_pkg::IDX_MASK[t], 8'h2f);
		end
		// High byte goes through the one shared temp byte
		wr(tcap_pkg::IDX_CAPH[0], 8'h12);
		wr(tcap_pkg::IDX_CAPL[0], 8'h34);
		rdc(tcap_pkg::IDX_CAPL[0], 8'h34);
		rdc(tcap_pkg::IDX_CAPL[1], 8'h00);
		rdc(tcap_pkg::IDX_CAPH[0], 8'h00);
		rdc(tcap_pkg::IDX_CAPL[0], 8'h34);
		rdc(tcap_pkg::IDX_CAPH[0], 8'h12);
		wr(tcap_pkg::IDX_CTRL, 8'h10);
		tick(2);
		chk(64'(top[15:0]), 64'h1234);
		wr(tcap_pkg::IDX_CTRL, 8'h00);
		tick(2);
		chk(64'(top[15:0]), 64'hffff);
		// Stop counters so the captured value is known
		hold <= 0;
		tick(50);
		hold <= 1;
		pin <= 4'hf;
		tick(8);
		pin <= 4'h0;
		chk(64'(req), 64'h0);
		for (int t = 0; t < 4; t++) begin
			rdc(tcap_pkg::IDX_CAPL[t], cnt[t*16+:8]);
			rdc(tcap_pkg::IDX_CAPH[t], cnt[t*16+8+:8]);
		end
		wr(tcap_pkg::IDX_CTRL, 8'h01);
		tick(2);
		for (int t = 0; t < 4; t++) begin
			chk(64'(req[t*5+4]), 64'h1);
			ack <= 20'(1) << (t * 5 + 4);
			tick(1);
			ack <= '0;
			tick(2);
			chk(64'(req[t*5+4]), 64'h0);
			for (int k = 0; k < 4; k++) begin
				fire <= 16'(1) << (k * 4 + t);
				tick(1);
				fire <= '0;
				tick(4);
				chk(64'(req[t*5+k]), 64'h1);
				chk(64'(irq), 64'h1);
				wr(tcap_pkg::IDX_FLAG[t], 8'(1 << k));
				tick(2);
				// Later timers still hold their capture flags
				exp_req = 20'h0_0000;
				for (int u = t + 1; u < 4; u++) begin
					exp_req[u*5+4] = 1'b1;
				end
				chk(64'(req), 64'(exp_req));
			end
		end
		// Masked flag waits, then requests once unmasked
		wr(tcap_pkg::IDX_MASK[2], 8'h00);
		fire <= 16'h0004;
		tick(1);
		fire <= '0;
		tick(4);
		chk(64'(req[10]), 64'h0);
		wr(tcap_pkg::IDX_MASK[2], 8'h2f);
		tick(2);
		chk(64'(req[10]), 64'h1);
		wr(tcap_pkg::IDX_CTRL, 8'h00);
		tick(2);
		chk(64'(irq), 64'h0);
		// Timer 1 captures from the comparator
		wr(tcap_pkg::IDX_CTRL, 8'h02);
		hold <= 0;
		tick(7);
		hold <= 1;
		cmp_o <= 1;
		tick(8);
		rdc(tcap_pkg::IDX_CAPL[0], cnt[7:0]);
		rdc(tcap_pkg::IDX_CAPH[0], cnt[15:8]);
		tally_and_finish();
	end
endmodule // tb_tcap_top

bind tcap_top tcap_chk tcap_chk_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.prdata(prdata), .vector_ack(vector_ack), .tmr_irq_req(tmr_irq_req),
	.irq(irq));

// ---- testbench/tcap_cnt_model.sv ----
// Counter-side model: four counters and one-cycle event strobes.
// Assumes pclk domain; the bench asks for strobes one cycle at a time.
`timescale 1ns/100ps
module tcap_cnt_model (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Bench control
	input  wire logic        hold,
	input  wire logic [15:0] fire,
	// Counter side
	output logic      [63:0] counter_value,
	output logic      [15:0] evt_q
);
	// Steps differ per timer so every capture value is distinct
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_value <= '0;
		end else if (!hold) begin
			for (int t = 0; t < 4; t++) begin
				counter_value[t*16+:16] <= counter_value[t*16+:16] + 16'(t + 1);
			end
		end
	end
	// Strobes last one cycle, as real counter logic gives them
	always_ff @(posedge pclk) begin
		evt_q <= fire;
	end
endmodule // tcap_cnt_model

// ---- testbench/tcap_top_properties.sv ----
// Bus and interrupt properties of the timer capture unit.
// Assumes it is bound to tcap_top and sees only its ports.
`timescale 1ns/100ps
module tcap_chk (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	// Interrupts
	input wire logic [19:0] vector_ack,
	input wire logic [19:0] tmr_irq_req,
	input wire logic        irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Answer timing: one wait state, single-cycle ready
	AST_WAIT_ONE: assert property (psel && penable && !pready |=> pready)
		else $error("answer not one cycle after access");
	AST_RDY_PULSE: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	AST_RDY_ACCESS: assert property (pready |-> psel && penable)
		else $error("ready outside access phase");
	// Data lines carry nothing outside a good read
	AST_ERR_DATA: assert property (pslverr |-> pready && prdata == '0)
		else $error("error without ready or with data");
	AST_HI_ZERO: assert property (prdata[31:8] == 24'h00_0000)
		else $error("upper read data not zero");
	AST_IDLE_ZERO: assert property (!pready |-> prdata == '0)
		else $error("read data outside ready cycle");
	// Line follows any request within one cycle; the timer 0 capture vector ack clears its request
	AST_IRQ_OR: assert property (|tmr_irq_req |-> ##[0:1] irq)
		else $error("request without interrupt line");
	AST_ACK_CLR: assert property (vector_ack[4] |-> ##2 !tmr_irq_req[4])
		else $error("vector did not clear capture request");
	COV_ERR: cover property (pslverr);
	COV_IRQ: cover property ($rose(irq));
	COV_ACK: cover property (vector_ack[4]);
endmodule // tcap_chk
